// ### logic/t1ovh_pkg.sv
package t1ovh_pkg;

  // Multiframe geometry
  localparam int unsigned MF_FRAMES = 72;
  localparam int unsigned SF_FRAMES = 12;
  localparam int unsigned FS_PER_MF = 36;
  localparam int unsigned ALIGN_BITS = 12;
  localparam int unsigned MSG_BITS = 24;
  localparam logic [6:0] MF_LAST = 7'h47;
  localparam logic [6:0] SF_LAST_POS = 7'h0b;

  // First-sent bit in bit 0: 000111000111
  localparam logic [11:0] ALIGN_PATTERN = 12'he38;

  // Code word, first-sent bit in bit 0: eight ones, 0, six code bits, 0
  localparam logic [3:0] BOC_LAST_BIT = 4'hf;
  localparam logic [7:0] BOC_ONES = 8'hff;

  // Register indices; byte address is four times the index
  localparam logic [8:0] IDX_RX_SLC_1 = 9'h064;
  localparam logic [8:0] IDX_RX_SLC_2 = 9'h065;
  localparam logic [8:0] IDX_RX_SLC_3 = 9'h066;
  localparam logic [8:0] IDX_RX_CTRL_1 = 9'h084;
  localparam logic [8:0] IDX_RX_CTRL_2 = 9'h085;
  localparam logic [8:0] IDX_RX_LS7 = 9'h096;
  localparam logic [8:0] IDX_TX_LINK_CTRL_2 = 9'h113;
  localparam logic [8:0] IDX_TX_FDL_BYTE = 9'h162;
  localparam logic [8:0] IDX_TX_BIT_CODE = 9'h163;
  localparam logic [8:0] IDX_TX_SLC_1 = 9'h164;
  localparam logic [8:0] IDX_TX_SLC_2 = 9'h165;
  localparam logic [8:0] IDX_TX_SLC_3 = 9'h166;
  localparam logic [8:0] IDX_TX_CTRL_1 = 9'h181;
  localparam logic [8:0] IDX_TX_CTRL_2 = 9'h182;
  localparam logic [8:0] IDX_TX_CTRL_3 = 9'h183;
  localparam logic [8:0] IDX_TX_LS1 = 9'h190;
  localparam logic [8:0] IDX_PORT_MODE = 9'h1f0;

  // Field positions
  localparam int unsigned B_SEND_BIT_CODE = 6;
  localparam int unsigned B_FBIT_PASSTHROUGH = 6;
  localparam int unsigned B_TX_SLC_ENABLE = 6;
  localparam int unsigned B_FS_SOURCE_SELECT = 7;
  localparam int unsigned B_TX_FRAME_FORMAT = 2;
  localparam int unsigned B_TX_SLC_FLAG = 4;
  localparam int unsigned B_SYNC_TIME_SELECT = 7;
  localparam int unsigned B_RX_FRAME_FORMAT = 5;
  localparam int unsigned B_FT_FS_CROSS_COUPLE = 3;
  localparam int unsigned B_RX_SLC_SYNC_ENABLE = 4;
  localparam int unsigned B_RX_SLC_FLAG = 3;
  localparam int unsigned B_T1_MODE = 0;
  localparam int unsigned BOC_CODE_W = 6;

  localparam logic [7:0] REG_RESET = 8'h00;

  // Frame index within its D4 superframe
  function automatic logic [3:0] sf_pos(input logic [6:0] idx);
    logic [6:0] r;
    r = idx;
    for (int k = 0; k < 6; k++) begin
      if (r >= 7'(SF_FRAMES)) begin
        r = r - 7'(SF_FRAMES);
      end
    end
    return r[3:0];
  endfunction

endpackage

// ### logic/t1ovh_fpos_if.sv
`timescale 1ns/1ps
interface t1ovh_fpos_if;
  logic strobe;
  logic sf_start;
  logic [6:0] idx;

  modport src (output strobe, output sf_start, input idx);
  modport cnt (input strobe, input sf_start, output idx);
endinterface

// ### logic/t1ovh_fpos.sv
`timescale 1ns/1ps
module t1ovh_fpos (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Frame timing
  t1ovh_fpos_if.cnt pos
);

  logic [6:0] idx_q;
  logic [6:0] idx_d;
  wire logic misaligned = t1ovh_pkg::sf_pos(idx_q) != 4'h0;
  wire logic at_end = idx_q == t1ovh_pkg::MF_LAST;

  // A superframe start that disagrees with the count marks this frame as frame 0,
  // so the frame after it is frame 1
  assign idx_d = (pos.sf_start && misaligned) ? 7'h01 :
                 at_end ? 7'h00 : idx_q + 7'h01;
  assign pos.idx = idx_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_q <= 7'h00;
    end else if (pos.strobe) begin
      idx_q <= idx_d;
    end
  end

endmodule

// ### logic/t1ovh_boc_gen.sv
`timescale 1ns/1ps
module t1ovh_boc_gen (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic send_i,
  input wire logic [5:0] code_i,
  input wire logic slot_i,
  // Serial bit for the current data link slot
  output logic bit_o
);

  logic [3:0] ptr_q;
  logic send_q;
  wire logic [15:0] word = {1'b0, code_i, 1'b0, t1ovh_pkg::BOC_ONES};
  wire logic start = send_i && !send_q;

  // Ones run is built here, so software only supplies the six code bits
  assign bit_o = send_i ? word[start ? 4'h0 : ptr_q] : 1'b1;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_q <= 4'h0;
      send_q <= 1'b0;
    end else begin
      send_q <= send_i;
      if (start) begin
        ptr_q <= slot_i ? 4'h1 : 4'h0;
      end else if (send_i && slot_i) begin
        ptr_q <= ptr_q + 4'h1;
      end
    end
  end

endmodule

// ### logic/t1ovh_top.sv
// Overview of operation
// - Track a 72-frame multiframe made of six D4 superframes.
// - Even frames carry Ft; the 36 Fs bits hold alignment and message.
// - Alignment pattern goes into the first twelve Fs bits automatically.
// - Remaining 24 Fs bits come from the three transmit link registers.
// - After sending the buffer set transmit latched status bit 4.
// - Without fresh writes the held values go out again next multiframe.
// - Load receive link registers with newest message and set receive flag on the same edge.
// - No receive flag unless the 12-bit alignment pattern is seen.
// - Bit code generator works in T1 operation only.
// - In ESF, setting the send-code bit starts code insertion at once; in D4 it inserts nothing.
// - The generator supplies the ones run itself.
// - Code words repeat while the send-code bit stays set.
`timescale 1ns/1ps
module t1ovh_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [10:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Transmit framing
  input wire logic tx_fbit_strobe_i,
  input wire logic tx_sf_start_i,
  input wire logic tx_serial_fbit_i,
  output logic tx_fbit_o,
  // Receive framing
  input wire logic rx_fbit_strobe_i,
  input wire logic rx_sf_start_i,
  input wire logic rx_fbit_i
);

  t1ovh_fpos_if tx_pos ();
  t1ovh_fpos_if rx_pos ();

  // Register storage
  logic [7:0] rx_slc_link_1_q;
  logic [7:0] rx_slc_link_2_q;
  logic [7:0] rx_slc_link_3_q;
  logic [7:0] tx_link_control_two_q;
  logic [7:0] tx_facility_link_byte_q;
  logic [7:0] tx_bit_code_q;
  logic [7:0] tx_slc_link_1_q;
  logic [7:0] tx_slc_link_2_q;
  logic [7:0] tx_slc_link_3_q;
  logic [7:0] tx_control_one_q;
  logic [7:0] tx_control_two_q;
  logic [7:0] tx_control_three_q;
  logic [7:0] rx_control_one_q;
  logic [7:0] rx_control_two_q;
  logic [7:0] port_mode_q;
  logic tx_slc_flag_q;
  logic rx_slc_flag_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic [23:0] tx_msg_q;
  logic [35:0] fs_hist_q;
  logic tx_fbit_q;

  // Bus decode
  wire logic [8:0] idx = adr_i[10:2];
  wire logic req = cyc_i && stb_i && !ack_q;
  wire logic wr = req && we_i && sel_i[0];
  wire logic [7:0] wd = dat_i[7:0];
  logic [7:0] rd;
  assign ack_o = ack_q;
  assign dat_o = dat_q;
  // Latched status words carry one flag each; other bits read as zero
  wire logic [7:0] rx_ls7_rd = 8'(rx_slc_flag_q) << t1ovh_pkg::B_RX_SLC_FLAG;
  wire logic [7:0] tx_ls1_rd = 8'(tx_slc_flag_q) << t1ovh_pkg::B_TX_SLC_FLAG;

  always_comb begin
    if (idx == t1ovh_pkg::IDX_RX_SLC_1) begin
      rd = rx_slc_link_1_q;
    end else if (idx == t1ovh_pkg::IDX_RX_SLC_2) begin
      rd = rx_slc_link_2_q;
    end else if (idx == t1ovh_pkg::IDX_RX_SLC_3) begin
      rd = rx_slc_link_3_q;
    end else if (idx == t1ovh_pkg::IDX_RX_CTRL_1) begin
      rd = rx_control_one_q;
    end else if (idx == t1ovh_pkg::IDX_RX_CTRL_2) begin
      rd = rx_control_two_q;
    end else if (idx == t1ovh_pkg::IDX_RX_LS7) begin
      rd = rx_ls7_rd;
    end else if (idx == t1ovh_pkg::IDX_TX_LINK_CTRL_2) begin
      rd = tx_link_control_two_q;
    end else if (idx == t1ovh_pkg::IDX_TX_FDL_BYTE) begin
      rd = tx_facility_link_byte_q;
    end else if (idx == t1ovh_pkg::IDX_TX_BIT_CODE) begin
      rd = tx_bit_code_q;
    end else if (idx == t1ovh_pkg::IDX_TX_SLC_1) begin
      rd = tx_slc_link_1_q;
    end else if (idx == t1ovh_pkg::IDX_TX_SLC_2) begin
      rd = tx_slc_link_2_q;
    end else if (idx == t1ovh_pkg::IDX_TX_SLC_3) begin
      rd = tx_slc_link_3_q;
    end else if (idx == t1ovh_pkg::IDX_TX_CTRL_1) begin
      rd = tx_control_one_q;
    end else if (idx == t1ovh_pkg::IDX_TX_CTRL_2) begin
      rd = tx_control_two_q;
    end else if (idx == t1ovh_pkg::IDX_TX_CTRL_3) begin
      rd = tx_control_three_q;
    end else if (idx == t1ovh_pkg::IDX_TX_LS1) begin
      rd = tx_ls1_rd;
    end else if (idx == t1ovh_pkg::IDX_PORT_MODE) begin
      rd = port_mode_q;
    end else begin
      rd = 8'h00;
    end
  end

  // Control fields
  wire logic t1_mode = port_mode_q[t1ovh_pkg::B_T1_MODE];
  wire logic tx_d4 = tx_control_three_q[t1ovh_pkg::B_TX_FRAME_FORMAT];
  wire logic passthrough = tx_control_one_q[t1ovh_pkg::B_FBIT_PASSTHROUGH];
  wire logic fs_from_block = !tx_control_two_q[t1ovh_pkg::B_FS_SOURCE_SELECT];
  wire logic tx_slc_on = t1_mode && tx_d4 && fs_from_block &&
                         tx_control_two_q[t1ovh_pkg::B_TX_SLC_ENABLE];
  wire logic send_code = t1_mode && tx_link_control_two_q[t1ovh_pkg::B_SEND_BIT_CODE];
  wire logic rx_slc_on = t1_mode && rx_control_one_q[t1ovh_pkg::B_RX_FRAME_FORMAT] &&
                         rx_control_one_q[t1ovh_pkg::B_FT_FS_CROSS_COUPLE] &&
                         rx_control_two_q[t1ovh_pkg::B_RX_SLC_SYNC_ENABLE];

  // Transmit frame position
  assign tx_pos.strobe = tx_fbit_strobe_i;
  assign tx_pos.sf_start = tx_sf_start_i;

  t1ovh_fpos u_tx_fpos (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pos(tx_pos.cnt)
  );

  wire logic [6:0] tx_idx = tx_pos.idx;
  wire logic [3:0] tx_sfp = t1ovh_pkg::sf_pos(tx_idx);
  wire logic tx_is_ft = !tx_idx[0];
  wire logic [5:0] tx_slot = tx_idx[6:1];
  wire logic ft_bit = !tx_idx[1];
  wire logic [2:0] sf_fs_slot = tx_sfp[3:1];

  // Fs content of the SLC multiframe
  wire logic slc_fs_bit = (tx_slot < 6'(t1ovh_pkg::ALIGN_BITS)) ?
                          t1ovh_pkg::ALIGN_PATTERN[tx_slot[3:0]] :
                          tx_msg_q[5'(tx_slot - 6'(t1ovh_pkg::ALIGN_BITS))];
  wire logic legacy_fs_bit = tx_facility_link_byte_q[sf_fs_slot];
  wire logic mf_start = tx_fbit_strobe_i && tx_idx == 7'h00;
  wire logic mf_done = tx_fbit_strobe_i && tx_idx == t1ovh_pkg::MF_LAST;
  wire logic [23:0] tx_msg_d = {tx_slc_link_3_q, tx_slc_link_2_q, tx_slc_link_1_q};

  // In ESF the data link occupies every other frame
  wire logic fdl_slot = tx_fbit_strobe_i && !tx_d4 && tx_is_ft;
  logic boc_bit;

  t1ovh_boc_gen u_boc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .send_i(send_code),
    .code_i(tx_bit_code_q[t1ovh_pkg::BOC_CODE_W-1:0]),
    .slot_i(fdl_slot),
    .bit_o(boc_bit)
  );

  // Source priority: ESF link, Ft, SLC formatter, legacy byte, then serial input
  logic gen_bit;
  logic gen_valid;
  always_comb begin
    gen_bit = tx_serial_fbit_i;
    gen_valid = 1'b0;
    if (!tx_d4) begin
      gen_valid = send_code && tx_is_ft;
      gen_bit = boc_bit;
    end else if (t1_mode && tx_is_ft) begin
      gen_valid = 1'b1;
      gen_bit = ft_bit;
    end else if (tx_slc_on) begin
      gen_valid = 1'b1;
      gen_bit = slc_fs_bit;
    end else if (t1_mode && fs_from_block) begin
      gen_valid = 1'b1;
      gen_bit = legacy_fs_bit;
    end
  end

  // Passthrough keeps the serial F-bit, so nothing generated reaches the line
  wire logic fbit_d = (gen_valid && !passthrough) ? gen_bit : tx_serial_fbit_i;
  assign tx_fbit_o = tx_fbit_q;

  // Receive frame position
  assign rx_pos.strobe = rx_fbit_strobe_i;
  assign rx_pos.sf_start = rx_sf_start_i;

  t1ovh_fpos u_rx_fpos (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pos(rx_pos.cnt)
  );

  wire logic [6:0] rx_idx = rx_pos.idx;
  wire logic [3:0] rx_sfp = t1ovh_pkg::sf_pos(rx_idx);
  wire logic rx_fs_take = rx_slc_on && rx_fbit_strobe_i && rx_idx[0];
  wire logic [35:0] hist_d = {rx_fbit_i, fs_hist_q[35:1]};
  wire logic rx_sf_end = rx_sfp == t1ovh_pkg::SF_LAST_POS[3:0];
  // Message bytes follow the alignment bits, first received in bit 0
  wire logic [7:0] rx_msg_1 = hist_d[t1ovh_pkg::ALIGN_BITS +: 8];
  wire logic [7:0] rx_msg_2 = hist_d[t1ovh_pkg::ALIGN_BITS + 8 +: 8];
  wire logic [7:0] rx_msg_3 = hist_d[t1ovh_pkg::ALIGN_BITS + 16 +: 8];
  // Only the oldest twelve bits are compared, so message data may false-match
  wire logic rx_aligned = hist_d[t1ovh_pkg::ALIGN_BITS-1:0] == t1ovh_pkg::ALIGN_PATTERN;
  wire logic rx_mf_hit = rx_fs_take && rx_sf_end && rx_aligned;

  // Flag clears: write one to the flag bit; a new event wins over the clear
  wire logic clr_tx = wr && idx == t1ovh_pkg::IDX_TX_LS1 && wd[t1ovh_pkg::B_TX_SLC_FLAG];
  wire logic clr_rx = wr && idx == t1ovh_pkg::IDX_RX_LS7 && wd[t1ovh_pkg::B_RX_SLC_FLAG];
  wire logic set_tx = tx_slc_on && mf_done;

  // The ack masks the request, so a strobe held through it is not taken twice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      dat_q <= req ? {24'h00_0000, rd} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_link_control_two_q <= t1ovh_pkg::REG_RESET;
      tx_facility_link_byte_q <= t1ovh_pkg::REG_RESET;
      tx_bit_code_q <= t1ovh_pkg::REG_RESET;
      tx_slc_link_1_q <= t1ovh_pkg::REG_RESET;
      tx_slc_link_2_q <= t1ovh_pkg::REG_RESET;
      tx_slc_link_3_q <= t1ovh_pkg::REG_RESET;
      tx_control_one_q <= t1ovh_pkg::REG_RESET;
      tx_control_two_q <= t1ovh_pkg::REG_RESET;
      tx_control_three_q <= t1ovh_pkg::REG_RESET;
      rx_control_one_q <= t1ovh_pkg::REG_RESET;
      rx_control_two_q <= t1ovh_pkg::REG_RESET;
      port_mode_q <= t1ovh_pkg::REG_RESET;
    end else if (wr) begin
      // Read-only and unmapped indices match nothing here, so those writes drop
      if (idx == t1ovh_pkg::IDX_TX_LINK_CTRL_2) begin
        tx_link_control_two_q <= wd;
      end
      if (idx == t1ovh_pkg::IDX_TX_FDL_BYTE) begin
        tx_facility_link_byte_q <= wd;
      end
      if (idx == t1ovh_pkg::IDX_TX_BIT_CODE) begin
        tx_bit_code_q <= wd;
      end
      if (idx == t1ovh_pkg::IDX_TX_SLC_1) begin
        tx_slc_link_1_q <= wd;
      end
      if (idx == t1ovh_pkg::IDX_TX_SLC_2) begin
        tx_slc_link_2_q <= wd;
      end
      if (idx == t1ovh_pkg::IDX_TX_SLC_3) begin
        tx_slc_link_3_q <= wd;
      end
      if (idx == t1ovh_pkg::IDX_TX_CTRL_1) begin
        tx_control_one_q <= wd;
      end
      if (idx == t1ovh_pkg::IDX_TX_CTRL_2) begin
        tx_control_two_q <= wd;
      end
      if (idx == t1ovh_pkg::IDX_TX_CTRL_3) begin
        tx_control_three_q <= wd;
      end
      if (idx == t1ovh_pkg::IDX_RX_CTRL_1) begin
        rx_control_one_q <= wd;
      end
      if (idx == t1ovh_pkg::IDX_RX_CTRL_2) begin
        rx_control_two_q <= wd;
      end
      if (idx == t1ovh_pkg::IDX_PORT_MODE) begin
        port_mode_q <= wd;
      end
    end
  end

  // Transmit line side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_msg_q <= 24'h00_0000;
      tx_slc_flag_q <= 1'b0;
      tx_fbit_q <= 1'b0;
    end else begin
      // Updated only at a strobe, so the line bit stands for the whole frame
      if (tx_fbit_strobe_i) begin
        tx_fbit_q <= fbit_d;
      end
      // Registers are sampled once per multiframe; unchanged ones repeat
      if (mf_start) begin
        tx_msg_q <= tx_msg_d;
      end
      if (set_tx) begin
        tx_slc_flag_q <= 1'b1;
      end else if (clr_tx) begin
        tx_slc_flag_q <= 1'b0;
      end
    end
  end

  // Receive line side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fs_hist_q <= 36'h0_0000_0000;
      rx_slc_link_1_q <= t1ovh_pkg::REG_RESET;
      rx_slc_link_2_q <= t1ovh_pkg::REG_RESET;
      rx_slc_link_3_q <= t1ovh_pkg::REG_RESET;
      rx_slc_flag_q <= 1'b0;
    end else begin
      if (rx_fs_take) begin
        fs_hist_q <= hist_d;
      end
      if (rx_mf_hit) begin
        rx_slc_link_1_q <= rx_msg_1;
        rx_slc_link_2_q <= rx_msg_2;
        rx_slc_link_3_q <= rx_msg_3;
        rx_slc_flag_q <= 1'b1;
      end else if (clr_rx) begin
        rx_slc_flag_q <= 1'b0;
      end
    end
  end

endmodule

// ### tb/t1ovh_top_sva.sv
`timescale 1ns/1ps
module t1ovh_top_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [10:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Framing
  input wire logic tx_fbit_strobe_i,
  input wire logic tx_sf_start_i,
  input wire logic tx_serial_fbit_i,
  input wire logic tx_fbit_o,
  input wire logic rx_fbit_strobe_i,
  input wire logic rx_sf_start_i,
  input wire logic rx_fbit_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow only the bits that fix the F-bit source: T1, D4, passthrough, SLC
  logic wr;
  logic [8:0] ri;
  logic [3:0] cfg_q, cfg_d;
  logic [6:0] nx_q, nx_d, cur_q;
  logic fr_on, slc_on;
  assign ri = adr_i[10:2];
  assign wr = cyc_i && stb_i && we_i && sel_i[0] && !ack_o;
  assign cfg_d[0] = (ri == t1ovh_pkg::IDX_PORT_MODE) ? dat_i[0] : cfg_q[0];
  assign cfg_d[1] = (ri == t1ovh_pkg::IDX_TX_CTRL_3) ? dat_i[2] : cfg_q[1];
  assign cfg_d[2] = (ri == t1ovh_pkg::IDX_TX_CTRL_1) ? dat_i[6] : cfg_q[2];
  assign cfg_d[3] = (ri == t1ovh_pkg::IDX_TX_CTRL_2) ? dat_i[6] && !dat_i[7] : cfg_q[3];
  assign fr_on = cfg_q[0] && cfg_q[1] && !cfg_q[2];
  assign slc_on = fr_on && cfg_q[3];
  assign nx_d = (nx_q == t1ovh_pkg::MF_LAST) ? 7'h00 : nx_q + 7'h01;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= 4'h0;
    end else if (wr) begin
      cfg_q <= cfg_d;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nx_q <= 7'h00;
      cur_q <= 7'h00;
    end else if (tx_fbit_strobe_i) begin
      nx_q <= nx_d;
      cur_q <= nx_q;
    end
  end
  property p_ack_next;
    cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_once;
    ack_o |=> !ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_dat_idle;
    !ack_o |-> dat_o == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_dat_hi;
    ack_o |-> dat_o[31:8] == 24'h0;
  endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("upper read data not zero");
  property p_hold;
    !tx_fbit_strobe_i |=> $stable(tx_fbit_o);
  endproperty
  a_hold: assert property (p_hold) else $error("F-bit changed between strobes");
  property p_ft;
    tx_fbit_strobe_i && fr_on && !nx_q[0] |=> tx_fbit_o == !cur_q[1];
  endproperty
  a_ft: assert property (p_ft) else $error("bad Ft bit");
  property p_align;
    tx_fbit_strobe_i && slc_on && nx_q[0] && nx_q < 7'h18
      |=> tx_fbit_o == t1ovh_pkg::ALIGN_PATTERN[cur_q[4:1]];
  endproperty
  a_align: assert property (p_align) else $error("bad alignment bit");
  property p_pass;
    tx_fbit_strobe_i && cfg_q[2] |=> tx_fbit_o == $past(tx_serial_fbit_i);
  endproperty
  a_pass: assert property (p_pass) else $error("serial F-bit not passed");
  property p_sf_ft;
    tx_fbit_strobe_i && tx_sf_start_i && fr_on |=> tx_fbit_o == 1'b1;
  endproperty
  a_sf_ft: assert property (p_sf_ft) else $error("superframe start off frame 0");
  c_slc: cover property (tx_fbit_strobe_i && slc_on && nx_q == t1ovh_pkg::MF_LAST);
  c_pass: cover property (tx_fbit_strobe_i && cfg_q[2]);
  c_read: cover property (cyc_i && stb_i && !we_i ##1 ack_o);
endmodule

bind t1ovh_top t1ovh_top_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .tx_fbit_strobe_i(tx_fbit_strobe_i),
  .tx_sf_start_i(tx_sf_start_i), .tx_serial_fbit_i(tx_serial_fbit_i),
  .tx_fbit_o(tx_fbit_o), .rx_fbit_strobe_i(rx_fbit_strobe_i),
  .rx_sf_start_i(rx_sf_start_i), .rx_fbit_i(rx_fbit_i));

// ### tb/t1ovh_far_end.sv
`timescale 1ns/1ps
module t1ovh_far_end (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Scenario control
  input wire logic bad_align_i,
  input wire logic [23:0] rx_msg_i,
  // Line
  input wire logic tx_fbit_i,
  output logic strobe_o,
  output logic sf_start_o,
  output logic rx_fbit_o,
  // Last complete transmit multiframe
  output logic mf_tick_o,
  output logic [71:0] last_mf_o
);
  logic [1:0] ph_q;
  logic [6:0] idx_q;
  logic [5:0] slot;
  logic [71:0] cap_q;
  logic fs_bit, bit_now;
  assign slot = idx_q[6:1];
  // Spoiling one alignment bit is enough to break the receive match
  assign fs_bit = (slot < 6'h0c) ?
    t1ovh_pkg::ALIGN_PATTERN[slot[3:0]] ^ (bad_align_i && slot == 6'h00) :
    rx_msg_i[slot - 6'h0c];
  assign bit_now = idx_q[0] ? fs_bit : !idx_q[1];
  assign strobe_o = !rst_i && ph_q == 2'h0;
  assign sf_start_o = strobe_o && t1ovh_pkg::sf_pos(idx_q) == 4'h0;
  // Between strobes the line shows the inverse, not a held bit
  assign rx_fbit_o = strobe_o ? bit_now : !bit_now;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_q <= 2'h0;
      idx_q <= 7'h00;
      cap_q <= 72'h0;
      last_mf_o <= 72'h0;
      mf_tick_o <= 1'b0;
    end else begin
      ph_q <= ph_q + 2'h1;
      mf_tick_o <= ph_q == 2'h2 && idx_q == t1ovh_pkg::MF_LAST;
      if (ph_q == 2'h2) begin
        cap_q[idx_q] <= tx_fbit_i;
        if (idx_q == t1ovh_pkg::MF_LAST) begin
          last_mf_o <= {tx_fbit_i, cap_q[70:0]};
        end
      end
      if (ph_q == 2'h3) begin
        idx_q <= (idx_q == t1ovh_pkg::MF_LAST) ? 7'h00 : idx_q + 7'h01;
      end
    end
  end
endmodule

// ### tb/test_t1_slc96_and_boc_overhead.sv
`timescale 1ns/1ps
module test_t1_slc96_and_boc_overhead;
  localparam int LIMIT = 20000;
  localparam logic [8:0] RW_LIST [7] = '{t1ovh_pkg::IDX_TX_SLC_1, t1ovh_pkg::IDX_TX_SLC_2,
    t1ovh_pkg::IDX_TX_SLC_3, t1ovh_pkg::IDX_TX_BIT_CODE, t1ovh_pkg::IDX_TX_CTRL_2,
    t1ovh_pkg::IDX_TX_LINK_CTRL_2, t1ovh_pkg::IDX_TX_FDL_BYTE};
  logic clk, rst, cyc, stb, we, ack, strobe, sfs, tx_ser, tx_fbit, rx_fbit, bad, mf_tick;
  logic [10:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [23:0] rx_msg;
  logic [71:0] last_mf;
  logic [7:0] rd;
  int err_total, checks, cyc_cnt;

  t1ovh_top dut_u (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .tx_fbit_strobe_i(strobe), .tx_sf_start_i(sfs), .tx_serial_fbit_i(tx_ser),
    .tx_fbit_o(tx_fbit), .rx_fbit_strobe_i(strobe), .rx_sf_start_i(sfs), .rx_fbit_i(rx_fbit));
  t1ovh_far_end far_u (.clk_i(clk), .rst_i(rst), .bad_align_i(bad), .rx_msg_i(rx_msg),
    .tx_fbit_i(tx_fbit), .strobe_o(strobe), .sf_start_o(sfs), .rx_fbit_o(rx_fbit),
    .mf_tick_o(mf_tick), .last_mf_o(last_mf));

  initial clk = 1'b0;
  always #20 clk = ~clk;

  task automatic complete_run;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == LIMIT) begin
      err_total++;
      complete_run();
    end
  end

  task automatic check(input logic [71:0] got, input logic [71:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Held until the edge that sees ack, then released for one cycle
  task automatic wb(input logic w, input logic [8:0] idx, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    sel <= 4'hf;
    wdat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [8:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [8:0] idx, input logic [7:0] e, input logic [7:0] m);
    wb(1'b0, idx, 8'h00);
    check(72'(rd & m), 72'(e));
  endtask

  task automatic wait_mf(input int n);
    repeat (n) begin
      do @(posedge clk); while (mf_tick !== 1'b1);
    end
  endtask

  function automatic logic [71:0] exp_mf(input logic [23:0] m);
    logic [71:0] v;
    for (int i = 0; i < 72; i++) begin
      if (i % 2 == 0) v[i] = (i / 2) % 2 == 0;
      else if (i < 24) v[i] = t1ovh_pkg::ALIGN_PATTERN[i / 2];
      else v[i] = m[i / 2 - 12];
    end
    return v;
  endfunction

  // Ft as in the multiframe, each superframe's Fs bits taken from the legacy byte
  function automatic logic [71:0] exp_sf(input logic [5:0] b);
    logic [71:0] v;
    v = exp_mf(24'h0);
    for (int i = 1; i < 72; i += 2) v[i] = b[(i % 12) / 2];
    return v;
  endfunction

  // True when the even F-bits follow the code word at any rotation
  function automatic logic boc_hit(input logic [71:0] f, input logic [5:0] c);
    logic [15:0] w;
    logic ok, hit;
    w = {1'b0, c, 1'b0, 8'hff};
    hit = 1'b0;
    for (int k = 0; k < 16; k++) begin
      ok = 1'b1;
      for (int j = 0; j < 36; j++) begin
        if (f[2 * j] !== w[(j + k) % 16]) ok = 1'b0;
      end
      hit = hit | ok;
    end
    return hit;
  endfunction

  initial begin
    {cyc, stb, we, adr, sel, wdat, tx_ser, bad} = '0;
    rst = 1'b1;
    rx_msg = 24'h5ac396;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (RW_LIST[i]) rdc(RW_LIST[i], 8'h00, 8'hff);
    wr(t1ovh_pkg::IDX_RX_SLC_1, 8'hff);
    rdc(t1ovh_pkg::IDX_RX_SLC_1, 8'h00, 8'hff);
    rdc(9'h1ff, 8'h00, 8'hff);
    wr(t1ovh_pkg::IDX_TX_BIT_CODE, 8'h3f);
    rdc(t1ovh_pkg::IDX_TX_BIT_CODE, 8'h3f, 8'hff);
    wr(t1ovh_pkg::IDX_PORT_MODE, 8'h01);
    wr(t1ovh_pkg::IDX_TX_CTRL_3, 8'h04);
    wr(t1ovh_pkg::IDX_TX_SLC_1, 8'ha5);
    wr(t1ovh_pkg::IDX_TX_SLC_2, 8'h3c);
    wr(t1ovh_pkg::IDX_TX_SLC_3, 8'h81);
    wr(t1ovh_pkg::IDX_TX_CTRL_2, 8'h40);
    wait_mf(1);
    rdc(t1ovh_pkg::IDX_TX_LS1, 8'h10, 8'h10);
    wr(t1ovh_pkg::IDX_TX_LS1, 8'h10);
    rdc(t1ovh_pkg::IDX_TX_LS1, 8'h00, 8'h10);
    wait_mf(1);
    check(last_mf, exp_mf(24'h813ca5));
    wait_mf(1);
    check(last_mf, exp_mf(24'h813ca5));
    wr(t1ovh_pkg::IDX_TX_SLC_1, 8'h0f);
    wait_mf(2);
    check(last_mf, exp_mf(24'h813c0f));
    wr(t1ovh_pkg::IDX_TX_CTRL_1, 8'h40);
    wait_mf(2);
    check(last_mf, 72'h0);
    wr(t1ovh_pkg::IDX_TX_CTRL_1, 8'h00);
    wr(t1ovh_pkg::IDX_RX_CTRL_1, 8'h28);
    wr(t1ovh_pkg::IDX_RX_CTRL_2, 8'h10);
    wait_mf(2);
    rdc(t1ovh_pkg::IDX_RX_LS7, 8'h08, 8'h08);
    rdc(t1ovh_pkg::IDX_RX_SLC_1, 8'h96, 8'hff);
    rdc(t1ovh_pkg::IDX_RX_SLC_2, 8'hc3, 8'hff);
    rdc(t1ovh_pkg::IDX_RX_SLC_3, 8'h5a, 8'hff);
    bad <= 1'b1;
    wait_mf(1);
    wr(t1ovh_pkg::IDX_RX_LS7, 8'h08);
    wait_mf(2);
    rdc(t1ovh_pkg::IDX_RX_LS7, 8'h00, 8'h08);
    wr(t1ovh_pkg::IDX_TX_FDL_BYTE, 8'h1c);
    wr(t1ovh_pkg::IDX_TX_CTRL_2, 8'h00);
    wait_mf(2);
    check(last_mf, exp_sf(6'h1c));
    wr(t1ovh_pkg::IDX_TX_CTRL_3, 8'h00);
    wr(t1ovh_pkg::IDX_TX_BIT_CODE, 8'h25);
    wr(t1ovh_pkg::IDX_TX_LINK_CTRL_2, 8'h40);
    wait_mf(2);
    check(72'(boc_hit(last_mf, 6'h25)), 72'h1);
    wr(t1ovh_pkg::IDX_PORT_MODE, 8'h00);
    wait_mf(2);
    check(72'(boc_hit(last_mf, 6'h25)), 72'h0);
    wr(t1ovh_pkg::IDX_PORT_MODE, 8'h01);
    wr(t1ovh_pkg::IDX_TX_LINK_CTRL_2, 8'h00);
    wait_mf(2);
    check(last_mf, 72'h0);
    complete_run();
  end
endmodule
